// ===== interrupt_pec_trap_controller_tb.sv
// Self-checking bench: AXI4-Lite master, request stimulus, expected queues.
// Assumes the core model returns from every hardware trap.
`timescale 1ns/1ps
module interrupt_pec_trap_controller_tb;
	import iptc_pkg::*;
	logic clk, rst_n, awv, wv, bready, arv, rready, nmi, stk, sw, slow;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rd;
	logic [NODES-1:0] preq;
	logic [EXT_N-1:0] ext;
	logic [4:0] flt;
	logic [15:0] sp;
	logic [6:0] swn;
	logic [3:0] base;
	logic [1:0] rsp;
	wire awr, wr_r, bv, arr, rv, vstb, pstb, pbyte, tact, done;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [23:0] vaddr, psrc, pdst;
	wire [6:0] vtrap;
	wire [3:0] vlvl, lvl;
	int error_cnt, compares, n, k, l, i;
	int exp_q[$];
	int pec_q[$];
	int fb[8] = '{TFB_NMI, TFB_STACK_OVERFLOW_FLAG, TFB_STACK_UNDERFLOW_FLAG, TFB_UNDEFINED_OPCODE_FLAG, TFB_PROTECTED_INSTR_FAULT_FLAG,
		TFB_ILLEGAL_OPERAND_ACCESS_FLAG, TFB_ILLEGAL_INSTR_ACCESS_FLAG, TFB_ILLEGAL_EXT_BUS_FLAG};
	iptc_top dut (.CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_r),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready), .PER_REQ_I(preq),
		.EXT_IRQ_I(ext), .NMI_I(nmi), .UNDEF_OPCODE_I(flt[0]),
		.PROT_FAULT_I(flt[1]), .ILL_OPERAND_I(flt[2]), .ILL_INSTR_I(flt[3]),
		.ILL_BUS_I(flt[4]), .STK_ACC_I(stk), .SP_I(sp), .SWTRAP_I(sw),
		.SWTRAP_NUM_I(swn), .CPU_LEVEL_I(lvl), .TRAP_DONE_I(done),
		.VEC_STB_O(vstb), .VEC_ADDR_O(vaddr), .VEC_TRAP_O(vtrap),
		.VEC_LEVEL_O(vlvl), .PEC_STB_O(pstb), .PEC_SRC_O(psrc),
		.PEC_DST_O(pdst), .PEC_BYTE_O(pbyte), .TRAP_ACTIVE_O(tact));
	iptc_cpu_model cpu (.clk_i(clk), .rst_n_i(rst_n), .trap_active_i(tact),
		.base_level_i(base), .slow_i(slow), .cpu_level_o(lvl),
		.trap_done_o(done));
	// ********
	// Tasks
	// ********
	task automatic chk(input string nm, input logic [31:0] e, s);
		compares++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic tally_and_finish;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
		end
		while (bv !== 1'b1);
		bready <= 1'b0;
		rsp = bresp;
	endtask
	task automatic rdr(input logic [11:0] a);
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end
		while (rv !== 1'b1);
		rready <= 1'b0;
		rd = rdata;
		rsp = rresp;
	endtask
	task automatic wait_vec;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (vstb !== 1'b1 && n < 60);
	endtask
	// Model side: every vector and transfer must match the queue head
	always @(posedge clk)
	begin
		if (vstb === 1'b1)
		begin
			if (exp_q.size() == 0)
				exp_q.push_back(32'hFFF);
			chk("vec_trap", exp_q[0] >> 4, vtrap);
			chk("vec_addr", (exp_q[0] >> 4) * 4, vaddr);
			chk("vec_lvl", exp_q[0] & 15, vlvl);
			chk("blocked", 0, tact & (vlvl != TRAP_LEVEL));
			void'(exp_q.pop_front());
		end
		if (pstb === 1'b1)
		begin
			if (pec_q.size() == 0)
				pec_q.push_back(-1);
			chk("pec_src", (pec_q[0] >> 16) & 32'h7FFF, psrc);
			chk("pec_dst", pec_q[0] & 32'hFFFF, pdst);
			chk("pec_byte", (pec_q[0] >> 31) & 1, pbyte);
			chk("pec_novec", 0, vstb);
			void'(pec_q.pop_front());
		end
	end
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		#100us;
		error_cnt++;
		tally_and_finish;
	end
	initial
	begin
		{rst_n, awv, wv, bready, arv, rready, nmi, stk, sw, slow} = '0;
		{awaddr, araddr, wdata, preq, ext, flt, sp, swn, base} = '0;
		void'($urandom(32'h513F));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rdr(OFS_STK_LOWER);
		chk("lower", 32'hFFFF, rd);
		rdr(OFS_NODE);
		chk("node0", 0, rd);
		rdr(12'h10C);
		chk("unmapped", RESP_SLVERR, rsp);
		wr(12'h10C, 32'h1);
		chk("wr_unmapped", RESP_SLVERR, rsp);
		exp_q.push_back(32'h1B5);
		wr(OFS_NODE + 12'h00C, 32'hC5);
		chk("bresp", RESP_OKAY, rsp);
		wait_vec;
		chk("lat", 1, n >= LAT_MIN_CLK && n <= LAT_MAX_CLK);
		for (i = 0; i < 6; i++)
		begin
			k = $urandom_range(NODES - 1, 0);
			l = $urandom_range(14, 1);
			wr(OFS_NODE + 12'(4 * k), 32'h40 | l);
			exp_q.push_back(NODE_TRAP[k] * 16 + l);
			preq[k] <= 1'b1;
			@(posedge clk);
			preq <= '0;
			wait_vec;
			chk("lat", 1, n >= LAT_MIN_CLK && n <= LAT_MAX_CLK);
		end
		base <= 4'h7;
		wr(OFS_NODE + 12'h010, 32'hC7);
		repeat (20) @(posedge clk);
		exp_q.push_back(32'h1C7);
		base <= 4'h6;
		wait_vec;
		base <= 4'h0;
		wr(OFS_PEC + 12'h020, 32'h002);
		wr(OFS_PEC + 12'h024, 32'h100);
		wr(OFS_PEC + 12'h028, 32'h300);
		wr(OFS_PEC + 12'h030, 32'h701);
		wr(OFS_PEC + 12'h034, 32'h040);
		wr(OFS_PEC + 12'h038, 32'h080);
		wr(OFS_NODE + 12'h014, 32'h543);
		wr(OFS_NODE + 12'h018, 32'h743);
		for (i = 0; i < 3; i++)
		begin
			if (i < 2)
				pec_q.push_back((32'h100 + 2 * i) << 16 | 32'h300);
			if (i > 0)
				exp_q.push_back(32'h1D3);
			pec_q.push_back(32'h8040_0080 + i);
			preq[6:5] <= 2'b11;
			@(posedge clk);
			preq <= '0;
			repeat (12) @(posedge clk);
		end
		chk("pec_left", 0, pec_q.size() + exp_q.size());
		rdr(OFS_PEC + 12'h030);
		chk("cont_cnt", 32'h701, rd);
		wr(OFS_EDGE_CFG, 32'h39);
		for (i = 0; i < 3; i++)
			wr(OFS_NODE + 12'(4 * i), 32'h42);
		exp_q = '{32'h182, 32'h1A2};
		ext <= 8'h07;
		repeat (30) @(posedge clk);
		exp_q = '{32'h192, 32'h1A2};
		ext <= 8'h00;
		repeat (30) @(posedge clk);
		chk("edge_left", 0, exp_q.size());
		base <= 4'h3;
		for (i = 0; i < 3; i++)
		begin
			swn <= (i == 0) ? 7'h7F : 7'($urandom_range(127, 0));
			@(posedge clk);
			exp_q.push_back(swn * 16 + 3);
			sw <= 1'b1;
			@(posedge clk);
			sw <= 1'b0;
			wait_vec;
		end
		wr(OFS_STK_UPPER, 32'h100);
		wr(OFS_STK_LOWER, 32'hF00);
		for (i = 0; i < 8; i++)
		begin
			exp_q.push_back(((i < 3) ? 2 + 2 * i : 10) * 16 + 15);
			sp <= (i == 1) ? 16'h0080 : 16'h1000;
			nmi <= (i == 0);
			stk <= (i == 1 || i == 2);
			flt <= (i > 2) ? 5'(1 << (i - 3)) : 5'h00;
			@(posedge clk);
			{nmi, stk, flt} <= '0;
			wait_vec;
			rdr(OFS_TRAP_FLAGS);
			chk("trap_flag", 1, rd[fb[i]]);
			wr(OFS_TRAP_FLAGS, 32'h0);
			repeat (10) @(posedge clk);
		end
		slow <= 1'b1;
		wr(OFS_NODE + 12'h01C, 32'h44);
		exp_q = '{32'h02F, 32'h1F4};
		nmi <= 1'b1;
		@(posedge clk);
		nmi <= 1'b0;
		wait_vec;
		preq[7] <= 1'b1;
		@(posedge clk);
		preq <= '0;
		repeat (60) @(posedge clk);
		chk("trap_left", 0, exp_q.size());
		rdr(OFS_STATUS);
		chk("status", 32'h04, rd);
		tally_and_finish;
	end
endmodule

// ===== iptc_cpu_model.sv
// Core model: holds the core level and returns from hardware traps.
// Assumes the controller flags a running trap on its trap-active output.
`timescale 1ns/1ps
module iptc_cpu_model
	import iptc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic trap_active_i,
	input wire logic [LVL_W-1:0] base_level_i,
	input wire logic slow_i,
	output logic [LVL_W-1:0] cpu_level_o,
	output logic trap_done_o
);
	int cnt;
	assign cpu_level_o = base_level_i;
	// Short or long handler; the long one leaves room for blocked requests
	always_ff @(posedge clk_i)
	begin
		trap_done_o <= 1'b0;
		if (!rst_n_i || !trap_active_i)
			cnt <= 0;
		else if (cnt == (slow_i ? 30 : 3))
		begin
			trap_done_o <= 1'b1;
			cnt <= 0;
		end
		else
			cnt <= cnt + 1;
	end
endmodule

// ===== iptc_pkg.sv
// Constants, register map and types of the interrupt, event-channel and
// trap controller. Assumes a 16-bit core with a 24-bit linear address space.
package iptc_pkg;
	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int NODES = 28;
	localparam int PEC_CH = 8;
	localparam int EXT_N = 8;
	localparam int LVL_W = 4;
	localparam int ADDR_W = 24;
	localparam int AXI_AW = 12;
	localparam int LAT_MIN_CLK = 5;
	localparam int LAT_MAX_CLK = 12;
	// ************************************************************
	// Register map (byte offsets)
	// ************************************************************
	localparam logic [11:0] OFS_NODE = 12'h000;
	localparam logic [11:0] OFS_PEC = 12'h100;
	localparam logic [11:0] OFS_TRAP_FLAGS = 12'h200;
	localparam logic [11:0] OFS_EDGE_CFG = 12'h204;
	localparam logic [11:0] OFS_STK_UPPER = 12'h208;
	localparam logic [11:0] OFS_STK_LOWER = 12'h20C;
	localparam logic [11:0] OFS_STATUS = 12'h210;
	// Node control fields
	localparam int NB_LVL = 0;
	localparam int NB_EN = 6;
	localparam int NB_REQ = 7;
	localparam int NB_PEC = 8;
	localparam int NB_CH = 9;
	localparam int NODE_W = 12;
	// Event channel control fields
	localparam int PB_CNT = 0;
	localparam int PB_BYTE = 8;
	localparam int PB_INCDST = 9;
	localparam int PB_CONT = 10;
	localparam int PEC_W = 11;
	// Trap flag register bits
	localparam int TFB_NMI = 15;
	localparam int TFB_STACK_OVERFLOW_FLAG = 14;
	localparam int TFB_STACK_UNDERFLOW_FLAG = 13;
	localparam int TFB_ILLEGAL_EXT_BUS_FLAG = 7;
	localparam int TFB_ILLEGAL_INSTR_ACCESS_FLAG = 3;
	localparam int TFB_ILLEGAL_OPERAND_ACCESS_FLAG = 2;
	localparam int TFB_PROTECTED_INSTR_FAULT_FLAG = 1;
	localparam int TFB_UNDEFINED_OPCODE_FLAG = 0;
	// Trap numbers; vector location is four times the number
	localparam logic [6:0] TN_RESET = 7'h00;
	localparam logic [6:0] TN_NMI = 7'h02;
	localparam logic [6:0] TN_STACK_OVERFLOW_FLAG = 7'h04;
	localparam logic [6:0] TN_STACK_UNDERFLOW_FLAG = 7'h06;
	localparam logic [6:0] TN_CLASS_B = 7'h0A;
	localparam logic [6:0] NODE_TRAP [NODES] = '{
		7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h1F,
		7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h2A, 7'h47,
		7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F, 7'h40, 7'h41, 7'h42,
		7'h43, 7'h44, 7'h45, 7'h46};
	localparam logic [LVL_W-1:0] TRAP_LEVEL = 4'hF;
	// Edge selection per external input
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Trap classes and AXI4-Lite response codes
	localparam logic [1:0] CLS_NONE = 2'h0;
	localparam logic [1:0] CLS_B = 2'h1;
	localparam logic [1:0] CLS_A = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum {ST_IDLE, ST_WAIT} iptc_state_t;
	typedef enum {K_NODE, K_PEC_CTL, K_PEC_SRC, K_PEC_DST, K_TFR, K_EDGE,
		K_STKU, K_STKL, K_STAT, K_NONE} iptc_kind_t;
endpackage

// ===== iptc_top.sv
// Interrupt, event-channel and trap controller with an AXI4-Lite register
// port. Assumes the core reports its level and trap return, and performs
// each vector branch and event-channel move that this block announces.
//
// Summary of operation
// - Vector issued five cycles after arbitration, inside twelve.
// - Each node selects vectored service or an event-channel transfer.
// - An event-channel transfer is a single-cycle strobe, never a vector.
// - Each transfer moves byte or word, then steps source or destination.
// - Transfer counter decrements per service, held in continuous mode.
// - Counter at zero, outside continuous mode, makes the node take its ordinary vector.
// - Eight independent event channels exist.
// - Each node has request, enable and level fields in its own register.
// - Level field is four bits: sixteen levels.
// - Service only for a level strictly above the current core level.
// - Each node branches to its own vector.
// - External inputs detect rising, falling or both edges.
// - Software trap numbers 00h-7Fh vector at four times, current level.
// - A request flag set by software is a valid request.
// - Node vector equals four times its trap number.
// - Hardware traps branch at once, regardless of enables.
// - Each hardware trap sets its own trap flag bit.
// - A trap preempts anything but a trap of equal or higher class.
// - While a trap runs, no interrupt or transfer is serviced.
// - Class A traps own vectors; class B faults share one vector.
// - Each stack access compares the pointer against both limits.
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module iptc_top
	import iptc_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [AXI_AW-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [AXI_AW-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic [NODES-1:0] PER_REQ_I,
	input wire logic [EXT_N-1:0] EXT_IRQ_I,
	input wire logic NMI_I,
	input wire logic UNDEF_OPCODE_I,
	input wire logic PROT_FAULT_I,
	input wire logic ILL_OPERAND_I,
	input wire logic ILL_INSTR_I,
	input wire logic ILL_BUS_I,
	input wire logic STK_ACC_I,
	input wire logic [15:0] SP_I,
	input wire logic SWTRAP_I,
	input wire logic [6:0] SWTRAP_NUM_I,
	input wire logic [LVL_W-1:0] CPU_LEVEL_I,
	input wire logic TRAP_DONE_I,
	output logic VEC_STB_O,
	output logic [ADDR_W-1:0] VEC_ADDR_O,
	output logic [6:0] VEC_TRAP_O,
	output logic [LVL_W-1:0] VEC_LEVEL_O,
	output logic PEC_STB_O,
	output logic [ADDR_W-1:0] PEC_SRC_O,
	output logic [ADDR_W-1:0] PEC_DST_O,
	output logic PEC_BYTE_O,
	output logic TRAP_ACTIVE_O
);
	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic iptc_kind_t kind_of(input logic [AXI_AW-1:0] a);
		kind_of = K_NONE;
		if (a[11:7] == OFS_NODE[11:7] && a[1:0] == 2'h0
			&& 32'(a[6:2]) < NODES)
			kind_of = K_NODE;
		else if (a[11:7] == OFS_PEC[11:7] && a[1:0] == 2'h0)
		begin
			case (a[3:2])
				2'h0: kind_of = K_PEC_CTL;
				2'h1: kind_of = K_PEC_SRC;
				2'h2: kind_of = K_PEC_DST;
				default: kind_of = K_NONE;
			endcase
		end
		else if (a == OFS_TRAP_FLAGS)
			kind_of = K_TFR;
		else if (a == OFS_EDGE_CFG)
			kind_of = K_EDGE;
		else if (a == OFS_STK_UPPER)
			kind_of = K_STKU;
		else if (a == OFS_STK_LOWER)
			kind_of = K_STKL;
		else if (a == OFS_STATUS)
			kind_of = K_STAT;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				merge[8*b +: 8] = d[8*b +: 8];
	endfunction

	function automatic logic [ADDR_W-1:0] vec_of(input logic [6:0] tn);
		vec_of = ADDR_W'({tn, 2'h0});
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	logic [NODE_W-1:0] node_ctl [NODES];
	logic [PEC_W-1:0] pec_ctl [PEC_CH];
	logic [ADDR_W-1:0] pec_src [PEC_CH];
	logic [ADDR_W-1:0] pec_dst [PEC_CH];
	logic [15:0] trap_flags, edge_cfg, stk_upper, stk_lower;
	logic [EXT_N-1:0] ext_prev;
	logic [3:0] hwt_pend;
	logic [1:0] trap_cls;
	logic swt_pend;
	logic [6:0] swt_num;
	iptc_state_t state;
	logic [3:0] wait_cnt;
	logic [4:0] sel;
	logic vec_int;
	logic aw_free, w_free;
	logic [AXI_AW-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// ************************************************************
	// Register port decode
	// ************************************************************
	wire wr_en = !aw_free && !w_free && !S_AXI_BVALID_O;
	iptc_kind_t wr_kind, rd_kind;
	assign wr_kind = kind_of(aw_addr);
	assign rd_kind = kind_of(S_AXI_ARADDR_I);
	wire [4:0] wr_node = aw_addr[6:2];
	wire [2:0] wr_ch = aw_addr[6:4];
	wire [4:0] rd_node = S_AXI_ARADDR_I[6:2];
	wire [2:0] rd_ch = S_AXI_ARADDR_I[6:4];
	logic [31:0] rd_data;
	always_comb
	begin
		rd_data = 32'h0;
		case (rd_kind)
			K_NODE: rd_data = 32'(node_ctl[rd_node]);
			K_PEC_CTL: rd_data = 32'(pec_ctl[rd_ch]);
			K_PEC_SRC: rd_data = 32'(pec_src[rd_ch]);
			K_PEC_DST: rd_data = 32'(pec_dst[rd_ch]);
			K_TFR: rd_data = 32'(trap_flags);
			K_EDGE: rd_data = 32'(edge_cfg);
			K_STKU: rd_data = 32'(stk_upper);
			K_STKL: rd_data = 32'(stk_lower);
			K_STAT: rd_data = 32'({state == ST_WAIT, trap_cls,
				swt_pend, node_ctl[sel][NB_LVL +: LVL_W]});
			default: rd_data = 32'h0;
		endcase
	end

	// ************************************************************
	// Edge detection and trap events
	// ************************************************************
	logic [EXT_N-1:0] ext_hit;
	always_comb
	begin
		for (int i = 0; i < EXT_N; i++)
			ext_hit[i] = (edge_cfg[2*i +: 2] == EDGE_RISE
				&& EXT_IRQ_I[i] && !ext_prev[i])
				|| (edge_cfg[2*i +: 2] == EDGE_FALL
				&& !EXT_IRQ_I[i] && ext_prev[i])
				|| (edge_cfg[2*i +: 2] == EDGE_BOTH
				&& EXT_IRQ_I[i] != ext_prev[i]);
	end
	wire [NODES-1:0] node_set = PER_REQ_I | NODES'(ext_hit);
	// Pointer below the upper limit register is an overflow
	wire stk_over = STK_ACC_I && SP_I < stk_upper;
	wire stk_under = STK_ACC_I && SP_I > stk_lower;
	wire cls_b_ev = UNDEF_OPCODE_I || PROT_FAULT_I || ILL_OPERAND_I
		|| ILL_INSTR_I || ILL_BUS_I;
	wire [3:0] hwt_ev = {NMI_I, stk_over, stk_under, cls_b_ev};
	logic [15:0] tf_set;
	always_comb
	begin
		tf_set = 16'h0;
		tf_set[TFB_NMI] = NMI_I;
		tf_set[TFB_STACK_OVERFLOW_FLAG] = stk_over;
		tf_set[TFB_STACK_UNDERFLOW_FLAG] = stk_under;
		tf_set[TFB_UNDEFINED_OPCODE_FLAG] = UNDEF_OPCODE_I;
		tf_set[TFB_PROTECTED_INSTR_FAULT_FLAG] = PROT_FAULT_I;
		tf_set[TFB_ILLEGAL_OPERAND_ACCESS_FLAG] = ILL_OPERAND_I;
		tf_set[TFB_ILLEGAL_INSTR_ACCESS_FLAG] = ILL_INSTR_I;
		tf_set[TFB_ILLEGAL_EXT_BUS_FLAG] = ILL_BUS_I;
	end

	// ************************************************************
	// Trap selection
	// ************************************************************
	wire [1:0] t_idx = hwt_pend[3] ? 2'h3 : hwt_pend[2] ? 2'h2
		: hwt_pend[1] ? 2'h1 : 2'h0;
	wire [1:0] t_cls = (t_idx == 2'h0) ? CLS_B : CLS_A;
	wire trap_go = |hwt_pend && t_cls > trap_cls;
	wire [6:0] t_num = (t_idx == 2'h3) ? TN_NMI : (t_idx == 2'h2) ? TN_STACK_OVERFLOW_FLAG
		: (t_idx == 2'h1) ? TN_STACK_UNDERFLOW_FLAG : TN_CLASS_B;
	wire sw_go = swt_pend && !trap_go;

	// ************************************************************
	// Node arbitration
	// ************************************************************
	logic win_valid;
	logic [4:0] win_idx;
	logic [LVL_W-1:0] win_lvl;
	always_comb
	begin
		win_valid = 1'b0;
		win_idx = 5'h0;
		win_lvl = '0;
		for (int i = 0; i < NODES; i++)
			if (node_ctl[i][NB_REQ] && node_ctl[i][NB_EN]
				&& node_ctl[i][NB_LVL +: LVL_W] > CPU_LEVEL_I
				&& (!win_valid || node_ctl[i][NB_LVL +: LVL_W] > win_lvl))
			begin
				win_valid = 1'b1;
				win_idx = 5'(i);
				win_lvl = node_ctl[i][NB_LVL +: LVL_W];
			end
	end
	wire [2:0] w_ch = node_ctl[win_idx][NB_CH +: 3];
	wire [7:0] w_cnt = pec_ctl[w_ch][PB_CNT +: 8];
	wire w_cont = pec_ctl[w_ch][PB_CONT];
	// An exhausted channel hands the node back to the vector path
	wire win_pec = node_ctl[win_idx][NB_PEC]
		&& (w_cnt != 8'h0 || w_cont);
	wire arb_ok = win_valid && trap_cls == CLS_NONE && !trap_go && !sw_go;
	wire pec_go = state == ST_IDLE && arb_ok && win_pec;
	wire wait_start = state == ST_IDLE && arb_ok && !win_pec;
	wire [LVL_W-1:0] sel_lvl = node_ctl[sel][NB_LVL +: LVL_W];
	wire sel_ok = node_ctl[sel][NB_REQ] && node_ctl[sel][NB_EN]
		&& sel_lvl > CPU_LEVEL_I && trap_cls == CLS_NONE;
	wire int_go = state == ST_WAIT && sel_ok && !trap_go && !sw_go
		&& 32'(wait_cnt) >= LAT_MIN_CLK - 1;
	wire [ADDR_W-1:0] step = pec_ctl[w_ch][PB_BYTE] ? ADDR_W'(1) : ADDR_W'(2);
	wire pec_last = !w_cont && w_cnt == 8'h1;
	wire [6:0] v_num = trap_go ? t_num : sw_go ? swt_num : NODE_TRAP[sel];

	// ************************************************************
	// Service sequencer
	// ************************************************************
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			state <= ST_IDLE;
			wait_cnt <= 4'h0;
			sel <= 5'h0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					wait_cnt <= 4'h1;
					if (wait_start)
					begin
						state <= ST_WAIT;
						sel <= win_idx;
					end
				end
				ST_WAIT:
				begin
					// Saturates; a held-off issue only slips behind traps
					if (32'(wait_cnt) < LAT_MAX_CLK)
						wait_cnt <= wait_cnt + 4'h1;
					if (int_go || !sel_ok)
						state <= ST_IDLE;
					else if (win_valid && !win_pec && win_lvl > sel_lvl)
						sel <= win_idx;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			hwt_pend <= 4'h0;
			trap_cls <= CLS_NONE;
			swt_pend <= 1'b0;
			swt_num <= 7'h0;
			ext_prev <= '0;
		end
		else
		begin
			ext_prev <= EXT_IRQ_I;
			hwt_pend <= (hwt_pend & ~(trap_go ? 4'(1) << t_idx : 4'h0))
				| hwt_ev;
			if (trap_go)
				trap_cls <= t_cls;
			else if (TRAP_DONE_I)
				trap_cls <= CLS_NONE;
			if (SWTRAP_I && !swt_pend)
			begin
				swt_pend <= 1'b1;
				swt_num <= SWTRAP_NUM_I;
			end
			else if (sw_go)
				swt_pend <= 1'b0;
		end
	end

	// ************************************************************
	// Outputs to the core
	// ************************************************************
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			VEC_STB_O <= 1'b0;
			VEC_ADDR_O <= '0;
			VEC_TRAP_O <= TN_RESET;
			VEC_LEVEL_O <= '0;
			vec_int <= 1'b0;
			PEC_STB_O <= 1'b0;
			PEC_SRC_O <= '0;
			PEC_DST_O <= '0;
			PEC_BYTE_O <= 1'b0;
			TRAP_ACTIVE_O <= 1'b0;
		end
		else
		begin
			VEC_STB_O <= trap_go || sw_go || int_go;
			vec_int <= int_go;
			VEC_TRAP_O <= v_num;
			VEC_ADDR_O <= vec_of(v_num);
			VEC_LEVEL_O <= trap_go ? TRAP_LEVEL
				: sw_go ? CPU_LEVEL_I : sel_lvl;
			PEC_STB_O <= pec_go;
			PEC_SRC_O <= pec_src[w_ch];
			PEC_DST_O <= pec_dst[w_ch];
			PEC_BYTE_O <= pec_ctl[w_ch][PB_BYTE];
			TRAP_ACTIVE_O <= trap_go || (trap_cls != CLS_NONE && !TRAP_DONE_I);
		end
	end

	// ************************************************************
	// Node and channel registers
	// ************************************************************
	logic [NODES-1:0] node_clr;
	always_comb
	begin
		for (int i = 0; i < NODES; i++)
			node_clr[i] = (int_go && sel == 5'(i))
				|| (pec_go && !pec_last && win_idx == 5'(i));
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			for (int i = 0; i < NODES; i++)
				node_ctl[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < NODES; i++)
			begin
				if (wr_en && wr_kind == K_NODE && wr_node == 5'(i))
					node_ctl[i] <= NODE_W'(merge(32'(node_ctl[i]), w_data,
						w_strb));
				else if (node_clr[i])
					node_ctl[i][NB_REQ] <= 1'b0;
				// Hardware set beats both software and service clears
				if (node_set[i])
					node_ctl[i][NB_REQ] <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			for (int c = 0; c < PEC_CH; c++)
			begin
				pec_ctl[c] <= '0;
				pec_src[c] <= '0;
				pec_dst[c] <= '0;
			end
		end
		else
		begin
			for (int c = 0; c < PEC_CH; c++)
			begin
				if (wr_en && wr_ch == 3'(c) && wr_kind == K_PEC_CTL)
					pec_ctl[c] <= PEC_W'(merge(32'(pec_ctl[c]), w_data,
						w_strb));
				else if (pec_go && w_ch == 3'(c) && !w_cont)
					pec_ctl[c][PB_CNT +: 8] <= w_cnt - 8'h1;
				if (wr_en && wr_ch == 3'(c) && wr_kind == K_PEC_SRC)
					pec_src[c] <= ADDR_W'(merge(32'(pec_src[c]), w_data,
						w_strb));
				else if (pec_go && w_ch == 3'(c) && !pec_ctl[c][PB_INCDST])
					pec_src[c] <= pec_src[c] + step;
				if (wr_en && wr_ch == 3'(c) && wr_kind == K_PEC_DST)
					pec_dst[c] <= ADDR_W'(merge(32'(pec_dst[c]), w_data,
						w_strb));
				else if (pec_go && w_ch == 3'(c) && pec_ctl[c][PB_INCDST])
					pec_dst[c] <= pec_dst[c] + step;
			end
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			trap_flags <= 16'h0;
			edge_cfg <= 16'h0;
			stk_upper <= 16'h0;
			stk_lower <= 16'hFFFF;
		end
		else
		begin
			// Software may clear a flag, but a new trap in that cycle wins
			trap_flags <= tf_set | ((wr_en && wr_kind == K_TFR)
				? 16'(merge(32'(trap_flags), w_data, w_strb))
				: trap_flags);
			if (wr_en && wr_kind == K_EDGE)
				edge_cfg <= 16'(merge(32'(edge_cfg), w_data, w_strb));
			if (wr_en && wr_kind == K_STKU)
				stk_upper <= 16'(merge(32'(stk_upper), w_data, w_strb));
			if (wr_en && wr_kind == K_STKL)
				stk_lower <= 16'(merge(32'(stk_lower), w_data, w_strb));
		end
	end

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			aw_free <= 1'b1;
			w_free <= 1'b1;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= RESP_OKAY;
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= 32'h0;
			S_AXI_RRESP_O <= RESP_OKAY;
		end
		else
		begin
			if (aw_free && S_AXI_AWVALID_I)
			begin
				aw_free <= 1'b0;
				aw_addr <= S_AXI_AWADDR_I;
			end
			if (w_free && S_AXI_WVALID_I)
			begin
				w_free <= 1'b0;
				w_data <= S_AXI_WDATA_I;
				w_strb <= S_AXI_WSTRB_I;
			end
			if (wr_en)
			begin
				aw_free <= 1'b1;
				w_free <= 1'b1;
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O <= (wr_kind == K_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
			else if (S_AXI_BREADY_I)
				S_AXI_BVALID_O <= 1'b0;
			if (S_AXI_ARREADY_O && S_AXI_ARVALID_I)
			begin
				S_AXI_ARREADY_O <= 1'b0;
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RDATA_O <= rd_data;
				S_AXI_RRESP_O <= (rd_kind == K_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
			else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
			begin
				S_AXI_RVALID_O <= 1'b0;
				S_AXI_ARREADY_O <= 1'b1;
			end
		end
	end
	assign S_AXI_AWREADY_O = aw_free;
	assign S_AXI_WREADY_O = w_free;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	sequence s_int_issue;
		VEC_STB_O && vec_int;
	endsequence
	a_int_latency: assert property (s_int_issue |-> $past(wait_start, 5))
		else $error("interrupt vector not five cycles after arbitration");
	a_pec_no_vector: assert property (PEC_STB_O |-> !VEC_STB_O)
		else $error("transfer strobe together with a vector");
	a_pec_count_dec: assert property (pec_go && !w_cont
		|=> pec_ctl[$past(w_ch)][PB_CNT +: 8] == $past(w_cnt) - 8'h1)
		else $error("transfer counter not decremented");
	a_pec_cont_hold: assert property (pec_go && w_cont
		|=> pec_ctl[$past(w_ch)][PB_CNT +: 8] == $past(w_cnt))
		else $error("continuous mode changed the counter");
	a_pec_ptr_step: assert property (pec_go && !$past(wr_en)
		&& !pec_ctl[w_ch][PB_INCDST] && !wr_en
		|=> pec_src[$past(w_ch)] == $past(pec_src[w_ch]) + $past(step))
		else $error("source pointer did not step");
	a_exhaust_keeps: assert property (pec_go && pec_last && !wr_en
		|=> node_ctl[$past(win_idx)][NB_REQ])
		else $error("last transfer dropped the node request");
	a_trap_flag_set: assert property (NMI_I |=> trap_flags[TFB_NMI])
		else $error("trap flag not set");
	a_trap_blocks: assert property (TRAP_ACTIVE_O
		|-> !PEC_STB_O && !(VEC_STB_O && vec_int))
		else $error("service granted during a trap");
	a_level_strict: assert property (wait_start
		|-> win_lvl > CPU_LEVEL_I)
		else $error("service at a level not above the core");
	a_vec_times4: assert property (VEC_STB_O
		|-> VEC_ADDR_O == ADDR_W'({VEC_TRAP_O, 2'h0}))
		else $error("vector not four times trap number");
	a_stack_over: assert property (stk_over |=> trap_flags[TFB_STACK_OVERFLOW_FLAG])
		else $error("stack overflow flag missing");
endmodule
